// *** verilog/pmw_pkg.sv ***
// Constants, register layout and types for the power mode and wakeup controller.
package pmw_pkg;
    localparam logic [7:0] ADDR_PB_WAKE = 8'hC0;
    localparam logic [7:0] ADDR_MODE = 8'hC4;
    localparam logic [7:0] ADDR_STATUS = 8'hC8;
    localparam logic [4:0] PB_WAKE_RST = 5'h00;
    localparam int SETTLE_CLOCKS = 2048;
    localparam int CPU_DIV = 4;
    localparam int PORT_A_PINS = 8;
    localparam int PORT_B_PINS = 5;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PDOWN = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam int CTRL_LSB = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Mode register bits 4..1; bit 0 reads as zero.
    typedef struct packed {
        logic [1:0] cpu_mode;
        logic slow_sel;
        logic hosc_stop;
    } pmw_ctrl_t;
    localparam pmw_ctrl_t CTRL_RST = pmw_ctrl_t'(4'h0);

    typedef enum logic [2:0] {ST_NORMAL, ST_SLOW, ST_GREEN, ST_PDOWN, ST_SETTLE} pmw_state_t;

    typedef struct packed {
        logic losc_en;
        logic hosc_en;
        logic cpu_run;
        logic [2:0] state;
    } pmw_status_t;

    typedef enum logic [1:0] {SEL_NONE, SEL_PB_WAKE, SEL_MODE, SEL_STATUS} pmw_sel_t;
endpackage

// *** verilog/pmw_power_mode.sv ***
// Operating mode, clock selection and wakeup control with an AXI4-Lite register port.
// What this block does
// - Slow mode instruction clock is low clock/4.
// - Low clock feeds watchdog and slow system clock.
// - Power-down stops the low oscillator.
// - Low oscillator only stops through power-down.
// - Mode field 01 stops both oscillators.
// - Power-down ends only on pin wake or reset.
// - Slow select one switches to low clock.
// - Mode field 10 enters green from running.
// - Green without timer wakes on pins, reset.
// - Enabled timer-0 overflow wakes green mode.
// - No execution in power-down or green.
// - Power-down wake resumes normal, pins only.
// - Green wake resumes normal or slow mode as slow select then reads.
// - Count 2048 high clocks after power-down wake.
// - Green wake has no settling delay.
// - Port A always wakes; port B per-pin enable.
// - Green wakes on ports, timer-0, counter-timer A.
// - Mode field: 00 normal, 01 down, 10 green.
// - Oscillator stop bit halts the high oscillator.
// - Slow select zero high clock, one low.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pmw_power_mode #(
    parameter int PA_W = pmw_pkg::PORT_A_PINS,
    parameter int PB_W = pmw_pkg::PORT_B_PINS,
    parameter int SETTLE = pmw_pkg::SETTLE_CLOCKS
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_hosc_clk,
    input wire logic i_losc_clk,
    input wire logic [PA_W-1:0] i_port_a,
    input wire logic [PB_W-1:0] i_port_b,
    input wire logic i_timer_zero_ovf,
    input wire logic i_timer_zero_enable,
    input wire logic i_ctimer_a_ovf,
    output logic o_hosc_enable,
    output logic o_losc_enable,
    output logic o_sys_clk_slow,
    output logic o_cpu_run,
    output logic o_cpu_tick,
    output logic o_wdt_losc_tick
);
    import pmw_pkg::*;

    localparam int CW = $clog2(SETTLE);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE - 1);
    localparam logic [1:0] DIV_LAST = 2'(CPU_DIV - 1);

    function automatic pmw_sel_t decode(input logic [7:0] addr);
        if (addr == ADDR_PB_WAKE) begin
            return SEL_PB_WAKE;
        end else if (addr == ADDR_MODE) begin
            return SEL_MODE;
        end else if (addr == ADDR_STATUS) begin
            return SEL_STATUS;
        end else begin
            return SEL_NONE;
        end
    endfunction

    pmw_state_t state_q;
    pmw_ctrl_t ctrl_q;
    pmw_status_t status;
    logic [PB_W-1:0] pb_wake_en_q;
    logic [1:0] hosc_s_q, losc_s_q;
    logic hosc_d3_q, losc_d3_q, hosc_edge, losc_edge, src_edge;
    logic [PA_W-1:0] pa_s1_q, pa_s2_q, pa_snap_q;
    logic [PB_W-1:0] pb_s1_q, pb_s2_q, pb_snap_q;
    logic running, enter_lp, wake_pin, wake_green, pd_wake, green_wake;
    logic [CW-1:0] settle_cnt_q;
    logic settle_done;
    logic [1:0] div_q;
    logic tick_q, wdt_tick_q;
    logic aw_full_q, w_full_q, bvalid_q, rvalid_q, do_wr;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    pmw_sel_t wr_sel;

    // Oscillator pins are sampled, so each must stay below a quarter of i_clock.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hosc_s_q <= 2'h0;
            losc_s_q <= 2'h0;
            hosc_d3_q <= 1'b0;
            losc_d3_q <= 1'b0;
        end else begin
            hosc_s_q <= {hosc_s_q[0], i_hosc_clk};
            losc_s_q <= {losc_s_q[0], i_losc_clk};
            hosc_d3_q <= hosc_s_q[1];
            losc_d3_q <= losc_s_q[1];
        end
    end
    assign hosc_edge = hosc_s_q[1] & ~hosc_d3_q;
    assign losc_edge = losc_s_q[1] & ~losc_d3_q;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pa_s1_q <= '0;
            pa_s2_q <= '0;
            pb_s1_q <= '0;
            pb_s2_q <= '0;
        end else begin
            pa_s1_q <= i_port_a;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= i_port_b;
            pb_s2_q <= pb_s1_q;
        end
    end

    assign running = (state_q == ST_NORMAL) || (state_q == ST_SLOW);
    assign enter_lp = running && ((ctrl_q.cpu_mode == MODE_PDOWN) ||
                                  (ctrl_q.cpu_mode == MODE_GREEN));

    // The snapshot is taken as the low-power state is entered, so a pin level
    // that differs from the entry level counts as a change.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pa_snap_q <= '0;
            pb_snap_q <= '0;
        end else if (enter_lp) begin
            pa_snap_q <= pa_s2_q;
            pb_snap_q <= pb_s2_q;
        end
    end

    assign wake_pin = (|(pa_s2_q ^ pa_snap_q)) |
                      (|((pb_s2_q ^ pb_snap_q) & pb_wake_en_q));
    assign wake_green = wake_pin | (i_timer_zero_ovf & i_timer_zero_enable) |
                        i_ctimer_a_ovf;
    assign pd_wake = (state_q == ST_PDOWN) && wake_pin;
    assign green_wake = (state_q == ST_GREEN) && wake_green;
    assign settle_done = (state_q == ST_SETTLE) && hosc_edge && (settle_cnt_q == SETTLE_LAST);

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_NORMAL;
        end else begin
            case (state_q)
                ST_NORMAL, ST_SLOW: begin
                    if (ctrl_q.cpu_mode == MODE_PDOWN) begin
                        state_q <= ST_PDOWN;
                    end else if (ctrl_q.cpu_mode == MODE_GREEN) begin
                        state_q <= ST_GREEN;
                    end else begin
                        state_q <= ctrl_q.slow_sel ? ST_SLOW : ST_NORMAL;
                    end
                end
                ST_PDOWN: begin
                    if (pd_wake) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_GREEN: begin
                    if (green_wake) begin
                        state_q <= ctrl_q.slow_sel ? ST_SLOW : ST_NORMAL;
                    end
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        state_q <= ST_NORMAL;
                    end
                end
                default: begin
                    state_q <= ST_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            settle_cnt_q <= '0;
        end else if (state_q != ST_SETTLE) begin
            settle_cnt_q <= '0;
        end else if (hosc_edge) begin
            settle_cnt_q <= settle_cnt_q + 1'b1;
        end
    end

    assign o_losc_enable = (state_q != ST_PDOWN);
    assign o_hosc_enable = (state_q == ST_SETTLE) ||
                           ((state_q != ST_PDOWN) && !ctrl_q.hosc_stop);
    assign o_sys_clk_slow = ctrl_q.slow_sel;
    assign o_cpu_run = running;
    assign src_edge = ctrl_q.slow_sel ? losc_edge : hosc_edge;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (!running) begin
            div_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (src_edge) begin
            div_q <= div_q + 2'h1;
            tick_q <= (div_q == DIV_LAST);
        end else begin
            tick_q <= 1'b0;
        end
    end
    assign o_cpu_tick = tick_q;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wdt_tick_q <= 1'b0;
        end else begin
            wdt_tick_q <= losc_edge && o_losc_enable;
        end
    end
    assign o_wdt_losc_tick = wdt_tick_q;

    // Write channel: address and data are held until both are present.
    assign o_awready = !aw_full_q && !bvalid_q;
    assign o_wready = !w_full_q && !bvalid_q;
    assign do_wr = aw_full_q && w_full_q && !bvalid_q;
    assign wr_sel = decode(awaddr_q);

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pb_wake_en_q <= PB_WAKE_RST[PB_W-1:0];
        end else if (do_wr && wstrb_q[0] && (wr_sel == SEL_PB_WAKE)) begin
            pb_wake_en_q <= wdata_q[PB_W-1:0];
        end
    end

    // A wake clears the mode field in the same edge; it wins over a bus write.
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else if (pd_wake) begin
            ctrl_q <= CTRL_RST;
        end else if (green_wake) begin
            ctrl_q.cpu_mode <= MODE_NORMAL;
        end else if (do_wr && wstrb_q[0] && (wr_sel == SEL_MODE)) begin
            ctrl_q.hosc_stop <= wdata_q[CTRL_LSB];
            ctrl_q.slow_sel <= wdata_q[CTRL_LSB+1];
            if (running && (wdata_q[CTRL_LSB+3:CTRL_LSB+2] != MODE_RSVD)) begin
                ctrl_q.cpu_mode <= wdata_q[CTRL_LSB+3:CTRL_LSB+2];
            end
        end
    end

    assign status = '{losc_en: o_losc_enable, hosc_en: o_hosc_enable,
                      cpu_run: o_cpu_run, state: state_q};

    assign o_arready = !rvalid_q;
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
            if (decode(i_araddr) == SEL_MODE) begin
                rdata_q <= {27'h0, ctrl_q, 1'b0};
            end else if (decode(i_araddr) == SEL_STATUS) begin
                rdata_q <= {26'h0, status};
            end else if (decode(i_araddr) == SEL_NONE) begin
                rresp_q <= RESP_SLVERR;
            end
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence settle_last_s;
        settle_done;
    endsequence
    sequence settle_mid_s;
        (state_q == ST_SETTLE) && !settle_done;
    endsequence

    pd_osc_off_a: assert property ((state_q == ST_PDOWN) |-> !o_hosc_enable && !o_losc_enable)
        else $error("oscillator running in power-down");
    cpu_halt_a: assert property ((state_q inside {ST_PDOWN, ST_GREEN, ST_SETTLE}) |-> ##1 !o_cpu_tick)
        else $error("instruction tick while halted");
    settle_end_a: assert property (settle_last_s |=> (state_q == ST_NORMAL) && o_cpu_run)
        else $error("settle did not end in normal mode");
    settle_hold_a: assert property (settle_mid_s |=> (state_q == ST_SETTLE))
        else $error("settle ended early");
    pd_exit_a: assert property (($past(state_q) == ST_PDOWN && state_q != ST_PDOWN) |-> (state_q == ST_SETTLE) && $past(wake_pin) && (ctrl_q == CTRL_RST))
        else $error("bad power-down exit");
    green_exit_a: assert property (green_wake |=> (state_q == ($past(ctrl_q.slow_sel) ? ST_SLOW : ST_NORMAL)) && (ctrl_q.cpu_mode == MODE_NORMAL))
        else $error("green wake did not return to prior mode");
    timer_wake_a: assert property (((state_q == ST_GREEN) && i_timer_zero_ovf && i_timer_zero_enable) |=> (state_q != ST_GREEN))
        else $error("timer-0 overflow did not wake green mode");
    green_entry_a: assert property ((running && ctrl_q.cpu_mode == MODE_GREEN) |=> (state_q == ST_GREEN) && !o_cpu_run)
        else $error("green mode not entered");
    slow_div_a: assert property ((running && ctrl_q.slow_sel && losc_edge && div_q == DIV_LAST) |=> o_cpu_tick)
        else $error("slow tick not on fourth low clock");
    hosc_stop_a: assert property ((running && ctrl_q.hosc_stop) |-> !o_hosc_enable && o_losc_enable)
        else $error("oscillator stop bit not honoured");
    pb_mask_a: assert property (((state_q == ST_PDOWN) && !(|(pa_s2_q ^ pa_snap_q)) && !(|((pb_s2_q ^ pb_snap_q) & pb_wake_en_q))) |=> (state_q == ST_PDOWN))
        else $error("power-down left without enabled pin change");
endmodule

// *** verif/pmw_far_model.sv ***
// Far-side model of the two oscillator pins feeding the controller.
`timescale 1ns/10ps
module pmw_far_model #(
    parameter int HALF_H = 200,
    parameter int HALF_L = 500
) (
    input wire logic i_hosc_enable,
    input wire logic i_losc_enable,
    output logic o_hosc_clk,
    output logic o_losc_clk
);
    // A stopped oscillator rests low, so a restart gives a clean first rising edge.
    initial begin
        o_hosc_clk = 1'h0;
        #13;
        forever begin
            #HALF_H;
            o_hosc_clk = i_hosc_enable ? !o_hosc_clk : 1'h0;
        end
    end
    initial begin
        o_losc_clk = 1'h0;
        #7;
        forever begin
            #HALF_L;
            o_losc_clk = i_losc_enable ? !o_losc_clk : 1'h0;
        end
    end
endmodule

// *** verif/pmw_power_mode_tb.sv ***
// Self-checking bench for the power mode and wakeup controller.
`timescale 1ns/10ps
module pmw_power_mode_tb;
    import pmw_pkg::*;
    localparam int SET_N = 8;
    logic i_clock = 1'h0, i_sys_rst = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, hosc, losc, hen, len, slow, run, tick, wtick;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] pa = 8'h00;
    logic [4:0] pb = 5'h00;
    logic t0 = 1'h0, t0en = 1'h0, tca = 1'h0, w;
    int n_errors = 0, checked = 0, hedges = 0, n;

    always #25 i_clock = !i_clock;
    always @(posedge hosc) hedges++;

    pmw_power_mode #(.SETTLE(SET_N)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid),
        .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp), .i_hosc_clk(hosc), .i_losc_clk(losc), .i_port_a(pa), .i_port_b(pb),
        .i_timer_zero_ovf(t0), .i_timer_zero_enable(t0en), .i_ctimer_a_ovf(tca),
        .o_hosc_enable(hen), .o_losc_enable(len), .o_sys_clk_slow(slow), .o_cpu_run(run),
        .o_cpu_tick(tick), .o_wdt_losc_tick(wtick));
    pmw_far_model far (.i_hosc_enable(hen), .i_losc_enable(len), .o_hosc_clk(hosc),
        .o_losc_clk(losc));

    task automatic report_and_stop;
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bus tasks start just after a rising edge and sample ready at the falling edge before
    // the edge that takes the item, so no race with the design's own updates.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, ga, gw;
        ga = 1'h0;
        gw = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(ga && gw)) begin
            @(negedge i_clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge i_clock);
            awvalid <= awvalid && !ta;
            wvalid <= wvalid && !tw;
            ga = ga || ta;
            gw = gw || tw;
        end
        bready <= 1'h1;
        ta = 1'h0;
        while (!ta) begin
            @(negedge i_clock);
            ta = bvalid;
            rs = bresp;
            @(posedge i_clock);
        end
        bready <= 1'h0;
    endtask

    task automatic rdr(input logic [7:0] a);
        logic t;
        t = 1'h0;
        araddr <= a;
        arvalid <= 1'h1;
        while (!t) begin
            @(negedge i_clock);
            t = arready;
            @(posedge i_clock);
        end
        arvalid <= 1'h0;
        rready <= 1'h1;
        t = 1'h0;
        while (!t) begin
            @(negedge i_clock);
            t = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge i_clock);
        end
        rready <= 1'h0;
    endtask

    function automatic logic [31:0] mv(input logic [1:0] m, input logic s, input logic h);
        return {27'h0, m, s, h, 1'h0};
    endfunction

    task automatic st(input logic [2:0] s, input logic r, input logic h, input logic l);
        rdr(ADDR_STATUS);
        chk("status", {26'h0, l, h, r, s}, rd);
    endtask

    task automatic kick(input logic a, input logic b);
        t0 <= a;
        tca <= b;
        @(posedge i_clock);
        t0 <= 1'h0;
        tca <= 1'h0;
    endtask

    task automatic waitrun(input int mx);
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
            w = run;
        end while (w !== 1'h1 && n < mx);
        @(posedge i_clock);
    endtask

    task automatic ticks(input int ec, input int ew);
        logic [31:0] c, d;
        c = 32'h0;
        d = 32'h0;
        repeat (320) begin
            @(negedge i_clock);
            c += tick;
            d += wtick;
        end
        @(posedge i_clock);
        chk("cpu ticks", ec, c);
        chk("wdt ticks", ew, d);
    endtask

    task automatic t_reset;
        chk("outputs", 32'hE, {hen, len, run, slow});
        st(ST_NORMAL, 1'h1, 1'h1, 1'h1);
        rdr(ADDR_PB_WAKE);
        chk("wake enable", 32'h0, rd);
        rdr(8'hD0);
        chk("read resp", RESP_SLVERR, rs);
        wr(8'hD0, 32'h1F);
        chk("write resp", RESP_SLVERR, rs);
    endtask

    task automatic t_slow;
        ticks(10, 16);
        wr(ADDR_MODE, mv(MODE_NORMAL, 1'h1, 1'h0));
        chk("slow select", 32'h1, slow);
        repeat (100) @(posedge i_clock);
        ticks(4, 16);
        wr(ADDR_MODE, mv(MODE_NORMAL, 1'h1, 1'h1));
        chk("osc enables", 32'h1, {hen, len});
        st(ST_SLOW, 1'h1, 1'h0, 1'h1);
        wr(ADDR_MODE, mv(MODE_NORMAL, 1'h1, 1'h0));
        // The oscillator settling wait is shortened to keep the run brief.
        repeat (100) @(posedge i_clock);
        wr(ADDR_MODE, mv(MODE_NORMAL, 1'h0, 1'h0));
        st(ST_NORMAL, 1'h1, 1'h1, 1'h1);
    endtask

    task automatic t_green;
        wr(ADDR_MODE, mv(MODE_GREEN, 1'h1, 1'h0));
        st(ST_GREEN, 1'h0, 1'h1, 1'h1);
        kick(1'h1, 1'h0);
        waitrun(10);
        chk("timer off", 32'h0, w);
        t0en <= 1'h1;
        kick(1'h1, 1'h0);
        waitrun(4);
        chk("timer wake", 32'h1, w);
        st(ST_SLOW, 1'h1, 1'h1, 1'h1);
        rdr(ADDR_MODE);
        chk("mode", mv(MODE_NORMAL, 1'h1, 1'h0), rd);
        wr(ADDR_MODE, mv(MODE_GREEN, 1'h0, 1'h0));
        kick(1'h0, 1'h1);
        waitrun(4);
        chk("ctimer wake", 32'h1, w);
        wr(ADDR_MODE, mv(MODE_GREEN, 1'h0, 1'h0));
        pa <= 8'h01;
        waitrun(4);
        chk("pin wake", 32'h1, w);
        st(ST_NORMAL, 1'h1, 1'h1, 1'h1);
        wr(ADDR_MODE, mv(MODE_RSVD, 1'h0, 1'h0));
        st(ST_NORMAL, 1'h1, 1'h1, 1'h1);
    endtask

    task automatic t_pdown;
        wr(ADDR_PB_WAKE, 32'h02);
        wr(ADDR_MODE, mv(MODE_PDOWN, 1'h1, 1'h0));
        st(ST_PDOWN, 1'h0, 1'h0, 1'h0);
        kick(1'h1, 1'h1);
        waitrun(10);
        chk("pd timers", 32'h0, w);
        pb <= 5'h01;
        waitrun(10);
        chk("pb masked", 32'h0, w);
        hedges = 0;
        pb <= 5'h03;
        waitrun(300);
        chk("pb wake", 32'h1, w);
        chk("settle", SET_N, hedges);
        chk("slow select", 32'h0, slow);
        rdr(ADDR_MODE);
        chk("mode", 32'h0, rd);
        wr(ADDR_MODE, mv(MODE_PDOWN, 1'h0, 1'h0));
        pa <= 8'h81;
        waitrun(300);
        chk("pa wake", 32'h1, w);
        st(ST_NORMAL, 1'h1, 1'h1, 1'h1);
    endtask

    initial begin
        repeat (5) @(posedge i_clock);
        i_sys_rst <= 1'h0;
        @(posedge i_clock);
        t_reset();
        t_slow();
        t_green();
        t_pdown();
        report_and_stop();
    end

    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule
